// ===== pmt_defs.vh
`ifndef PMT_DEFS_VH
`define PMT_DEFS_VH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define PMT_OFF_PTR_LOW   12'h000
`define PMT_OFF_PTR_HIGH  12'h004
`define PMT_OFF_TBL_HIGH  12'h008
`define PMT_OFF_STATUS    12'h00C
`define PMT_OFF_PROG_ADDR 12'h010
`define PMT_OFF_PROG_DATA 12'h014
`define PMT_OFF_CTRL      12'h018
// ---------------------------------------------------------------
// sizes and reset values
// ---------------------------------------------------------------
`define PMT_WORDS_SMALL   13'h0C00
`define PMT_WORDS_LARGE   13'h1000
`define PMT_PAGE_BITS     8
`define PMT_RESET_VECTOR  12'h000
`define PMT_PTR_RST       8'h00
`define PMT_FLAGS_RST     4'h0
// status flag positions
`define PMT_FLAG_C        0
`define PMT_FLAG_AC       1
`define PMT_FLAG_Z        2
`define PMT_FLAG_OV       3
// ---------------------------------------------------------------
// timing: four system clocks per instruction cycle
// ---------------------------------------------------------------
`define PMT_PHASES        2'h3
`define PMT_TABLE_CYCLES  2
// serial programming frame: direction, 12 address bits, 16 data bits
`define PMT_SER_ADDR_END  5'h0C
`define PMT_SER_LAST      5'h1C
// alu operations
`define PMT_ALU_ADD 4'h0
`define PMT_ALU_ADC 4'h1
`define PMT_ALU_SUB 4'h2
`define PMT_ALU_SBC 4'h3
`define PMT_ALU_AND 4'h4
`define PMT_ALU_OR  4'h5
`define PMT_ALU_XOR 4'h6
`define PMT_ALU_CPL 4'h7
`define PMT_ALU_INC 4'h8
`define PMT_ALU_DEC 4'h9
`define PMT_ALU_RR  4'hA
`define PMT_ALU_RL  4'hB
`define PMT_ALU_RRC 4'hC
`define PMT_ALU_RLC 4'hD
// table read kinds
`define PMT_TBL_STD       2'h0
`define PMT_TBL_LAST      2'h1
`define PMT_TBL_EXT       2'h2
`define PMT_TBL_EXT_LAST  2'h3
`endif

// ===== pmt_dm_model.sv
`default_nettype none
module pmt_dm_model (
  // design side
  input wire logic        clk_sys,
  input wire logic        dmWrite,
  input wire logic [10:0] dmAddr,
  input wire logic [7:0]  dmData,
  // bench side
  output var int          wrCount
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------
  // data memory, all sectors
  // ---------------------------------------------------------
  logic [7:0] mem [0:2047];
  initial wrCount = 0;
  always @(posedge clk_sys)
  begin
    if (dmWrite === 1'b1)
    begin
      mem[dmAddr] <= dmData;
      wrCount <= wrCount + 1;
    end
  end
endmodule // pmt_dm_model
`default_nettype wire

// ===== pmt_program_memory.v
// How it works
// R1: 16-bit program words, 3K or 4K deep
// R2: reset starts fetch at word zero
// R3: table address is high:low pointer bytes
// R4: low table byte goes to operand register
// R5: high table byte overwrites table high register
// R6: standard form only targets sector zero
// R7: last-page form ignores high pointer
// R8: last-page form uses top page number
// R9: low pointer picks word inside page
// R10: table instructions take two instruction cycles
// R11: table high register readable and writable
// R12: software masks interrupts around shared table reads
// R13: alu result goes to designated register
// R14: alu updates carry, zero and related flags
// R15: serial programming both ways over one line
//
// Added by the designer: the register addresses and register access over APB.
`include "pmt_defs.vh"
`default_nettype none
module pmt_program_memory #(
  parameter LARGE = 1
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // instruction decoder
  input  wire        jumpReq,
  input  wire [11:0] jumpAddr,
  input  wire        tableReq,
  input  wire [1:0]  tableKind,
  input  wire [10:0] tableDest,
  input  wire        aluReq,
  input  wire [3:0]  aluOp,
  input  wire [7:0]  aluA,
  input  wire [7:0]  aluB,
  input  wire [10:0] aluDest,
  output reg  [11:0] pc,
  output reg  [15:0] instrWord,
  output reg         instrValid,
  output reg         cycleEnable,
  output reg         tableBusy,
  output reg         tableDestError,
  output reg  [3:0]  statusFlags,
  // data memory write port
  output reg         dmWrite,
  output reg  [10:0] dmAddr,
  output reg  [7:0]  dmData,
  // serial programming pins
  input  wire        prog_serial_clock,
  input  wire        prog_serial_data_in,
  output reg         prog_serial_data_out,
  output reg         prog_serial_data_oe
);

  // ---------------------------------------------------------------
  // program store
  // ---------------------------------------------------------------
  localparam [12:0] WORDS = LARGE ? `PMT_WORDS_LARGE : `PMT_WORDS_SMALL;
  localparam [3:0] LAST_PAGE = LARGE ? 4'hF : 4'hB;

  reg [15:0] progMem [0:4095]; // R1
  reg [7:0]  ptrLow;
  reg [7:0]  ptrHigh;
  reg [7:0]  table_data_high;
  reg [11:0] progAddr;
  reg        serEnable;
  reg [1:0]  phase;
  reg        tablePending;
  reg [1:0]  pendKind;
  reg [10:0] pendDest;

  wire apbSetup  = psel & ~penable;
  wire apbAccess = psel & penable & pready;
  wire apbWr     = apbAccess & pwrite;

  // ---------------------------------------------------------------
  // instruction cycle enable: four clocks make one cycle
  // ---------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      phase       <= 2'h0;
      cycleEnable <= 1'b0;
    end
    else
    begin
      phase       <= phase + 2'h1;
      cycleEnable <= (phase == `PMT_PHASES);
    end
  end

  // ---------------------------------------------------------------
  // table address
  // ---------------------------------------------------------------
  reg [11:0] tableAddr;
  always @*
  begin
    if (pendKind == `PMT_TBL_LAST || pendKind == `PMT_TBL_EXT_LAST)
      tableAddr = {LAST_PAGE, ptrLow};  // R7 R8 R9
    else
      tableAddr = {ptrHigh[3:0], ptrLow}; // R3 R9
  end

  // out-of-range words read as zero on the smaller store
  wire [15:0] tableWord = ({1'b0, tableAddr} < WORDS) ?
                          progMem[tableAddr] : 16'h0000;
  wire [15:0] fetchWord = ({1'b0, pc} < WORDS) ? progMem[pc] : 16'h0000;

  // ---------------------------------------------------------------
  // alu
  // ---------------------------------------------------------------
  reg [8:0] aluSum;
  reg [7:0] aluRes;
  reg       aluC;
  reg       aluAc;
  reg       aluOv;
  always @*
  begin
    aluSum = 9'h000;
    aluRes = 8'h00;
    aluC   = statusFlags[`PMT_FLAG_C];
    aluAc  = statusFlags[`PMT_FLAG_AC];
    aluOv  = statusFlags[`PMT_FLAG_OV];
    case (aluOp)
      `PMT_ALU_ADD, `PMT_ALU_ADC:
      begin
        aluSum = {1'b0, aluA} + {1'b0, aluB} +
                 {8'h00, (aluOp == `PMT_ALU_ADC) & aluC};
        aluRes = aluSum[7:0];
        aluC   = aluSum[8];
        aluAc  = (aluA[3:0] + aluB[3:0]) > 5'h0F;
        aluOv  = (aluA[7] == aluB[7]) & (aluRes[7] != aluA[7]);
      end
      `PMT_ALU_SUB, `PMT_ALU_SBC:
      begin
        // carry set means no borrow
        aluSum = {1'b0, aluA} + {1'b0, ~aluB} +
                 {8'h00, (aluOp == `PMT_ALU_SUB) | aluC};
        aluRes = aluSum[7:0];
        aluC   = aluSum[8];
        aluAc  = aluA[3:0] >= aluB[3:0];
        aluOv  = (aluA[7] != aluB[7]) & (aluRes[7] != aluA[7]);
      end
      `PMT_ALU_AND: aluRes = aluA & aluB;
      `PMT_ALU_OR:  aluRes = aluA | aluB;
      `PMT_ALU_XOR: aluRes = aluA ^ aluB;
      `PMT_ALU_CPL: aluRes = ~aluA;
      `PMT_ALU_INC: aluRes = aluA + 8'h01;
      `PMT_ALU_DEC: aluRes = aluA - 8'h01;
      `PMT_ALU_RR:  aluRes = {aluA[0], aluA[7:1]};
      `PMT_ALU_RL:  aluRes = {aluA[6:0], aluA[7]};
      `PMT_ALU_RRC:
      begin
        aluRes = {aluC, aluA[7:1]};
        aluC   = aluA[0];
      end
      `PMT_ALU_RLC:
      begin
        aluRes = {aluA[6:0], aluC};
        aluC   = aluA[7];
      end
      default: aluRes = aluA;
    endcase
  end

  wire aluFlagsZ = (aluOp != `PMT_ALU_RR) & (aluOp != `PMT_ALU_RL) &
                   (aluOp != `PMT_ALU_RRC) & (aluOp != `PMT_ALU_RLC);

  // ---------------------------------------------------------------
  // fetch, table read and alu write-back
  // ---------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pc              <= `PMT_RESET_VECTOR; // R2
      instrWord       <= 16'h0000;
      instrValid      <= 1'b0;
      tablePending    <= 1'b0;
      tableBusy       <= 1'b0;
      tableDestError  <= 1'b0;
      pendKind        <= `PMT_TBL_STD;
      pendDest        <= 11'h000;
      table_data_high <= `PMT_PTR_RST;
      statusFlags     <= `PMT_FLAGS_RST;
      dmWrite         <= 1'b0;
      dmAddr          <= 11'h000;
      dmData          <= 8'h00;
    end
    else
    begin
      instrValid <= 1'b0;
      dmWrite    <= 1'b0;
      if (apbWr && paddr == `PMT_OFF_TBL_HIGH)
        table_data_high <= pwdata[7:0]; // R11
      if (cycleEnable)
      begin
        if (tablePending)
        begin
          // second cycle: the fetch slot is spent on the table word
          tablePending    <= 1'b0; // R10
          tableBusy       <= 1'b0;
          dmWrite         <= 1'b1;
          dmAddr          <= pendDest;
          dmData          <= tableWord[7:0]; // R4
          table_data_high <= tableWord[15:8]; // R5
        end
        else
        begin
          instrWord  <= fetchWord;
          instrValid <= 1'b1;
          pc         <= jumpReq ? jumpAddr : pc + 12'h001;
          if (tableReq)
          begin
            // standard forms reach sector zero only
            if (!tableKind[1] && tableDest[10:8] != 3'h0)
              tableDestError <= 1'b1; // R6
            else
            begin
              tablePending <= 1'b1; // R10
              tableBusy    <= 1'b1;
              pendKind     <= tableKind;
              pendDest     <= tableDest;
            end
          end
          else if (aluReq)
          begin
            dmWrite <= 1'b1; // R13
            dmAddr  <= aluDest;
            dmData  <= aluRes;
            statusFlags[`PMT_FLAG_C]  <= aluC; // R14
            statusFlags[`PMT_FLAG_AC] <= aluAc;
            statusFlags[`PMT_FLAG_OV] <= aluOv;
            if (aluFlagsZ)
              statusFlags[`PMT_FLAG_Z] <= (aluRes == 8'h00);
          end
        end
      end
      // software clear loses to a new error in the same cycle
      if (apbWr && paddr == `PMT_OFF_STATUS && pwdata[8] &&
          !(cycleEnable && !tablePending && tableReq && !tableKind[1] &&
            tableDest[10:8] != 3'h0))
        tableDestError <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // serial programming link
  // ---------------------------------------------------------------
  reg [1:0]  serClkSync;
  reg [1:0]  serDatSync;
  reg        serClkLast;
  reg [4:0]  serCount;
  reg        serRead;
  reg [11:0] serAddr;
  reg [15:0] serShift;
  reg        serStore;
  wire       serRise = serClkSync[1] & ~serClkLast;
  wire [15:0] serWord = progMem[{serAddr[10:0], serDatSync[1]}];

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      serClkSync           <= 2'b00;
      serDatSync           <= 2'b00;
      serClkLast           <= 1'b0;
      serCount             <= 5'h00;
      serRead              <= 1'b0;
      serAddr              <= 12'h000;
      serShift             <= 16'h0000;
      serStore             <= 1'b0;
      prog_serial_data_out <= 1'b0;
      prog_serial_data_oe  <= 1'b0;
    end
    else
    begin
      serClkSync <= {serClkSync[0], prog_serial_clock};
      serDatSync <= {serDatSync[0], prog_serial_data_in};
      serClkLast <= serClkSync[1];
      serStore   <= 1'b0;
      if (!serEnable)
      begin
        serCount            <= 5'h00;
        prog_serial_data_oe <= 1'b0;
      end
      else if (serRise)
      begin
        serCount <= (serCount == `PMT_SER_LAST) ? 5'h00 : serCount + 5'h01;
        if (serCount == 5'h00)
          serRead <= serDatSync[1];
        else if (serCount <= `PMT_SER_ADDR_END)
          serAddr <= {serAddr[10:0], serDatSync[1]};
        if (serCount == `PMT_SER_ADDR_END && serRead)
        begin
          // read frame: the device turns the line round and shifts out
          // top bit leaves at once, else the last bit meets the oe drop
          serShift             <= {serWord[14:0], 1'b0};
          prog_serial_data_oe  <= 1'b1; // R15
          prog_serial_data_out <= serWord[15];
        end
        else if (serCount > `PMT_SER_ADDR_END)
        begin
          if (serRead)
          begin
            prog_serial_data_out <= serShift[15];
            serShift             <= {serShift[14:0], 1'b0};
          end
          else
            serShift <= {serShift[14:0], serDatSync[1]}; // R15
          if (serCount == `PMT_SER_LAST)
          begin
            prog_serial_data_oe <= 1'b0;
            serStore            <= ~serRead;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // program store writes: apb loader and serial link
  // ---------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (serStore)
      progMem[serAddr] <= serShift; // R15
    else if (apbWr && paddr == `PMT_OFF_PROG_DATA)
      progMem[progAddr] <= pwdata[15:0]; // R1
  end

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ptrLow    <= `PMT_PTR_RST;
      ptrHigh   <= `PMT_PTR_RST;
      progAddr  <= 12'h000;
      serEnable <= 1'b0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end
    else
    begin
      // one wait-free access phase: ready is raised from the setup cycle
      pready  <= apbSetup;
      pslverr <= 1'b0;
      if (apbWr)
      begin
        case (paddr)
          `PMT_OFF_PTR_LOW:   ptrLow    <= pwdata[7:0]; // R3
          `PMT_OFF_PTR_HIGH:  ptrHigh   <= pwdata[7:0];
          `PMT_OFF_PROG_ADDR: progAddr  <= pwdata[11:0];
          `PMT_OFF_PROG_DATA: progAddr  <= progAddr + 12'h001;
          `PMT_OFF_CTRL:      serEnable <= pwdata[0];
          default:            ;
        endcase
      end
      if (apbSetup)
      begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `PMT_OFF_PTR_LOW:   prdata[7:0]  <= ptrLow;
          `PMT_OFF_PTR_HIGH:  prdata[7:0]  <= ptrHigh;
          `PMT_OFF_TBL_HIGH:  prdata[7:0]  <= table_data_high; // R11
          `PMT_OFF_STATUS:    prdata[13:0] <= {tableBusy, tableDestError,
                                               4'h0, 4'h0, statusFlags};
          `PMT_OFF_PROG_ADDR: prdata[11:0] <= progAddr;
          `PMT_OFF_PROG_DATA: prdata[15:0] <= progMem[progAddr];
          `PMT_OFF_CTRL:      prdata[0]    <= serEnable;
          default:            pslverr      <= 1'b1;
        endcase
      end
    end
  end

endmodule // pmt_program_memory
`default_nettype wire

// ===== pmt_program_memory_assertions.sv
`include "pmt_defs.vh"
`default_nettype none
module pmt_pm_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // decoder side
  input wire logic        tableReq,
  input wire logic        aluReq,
  input wire logic [11:0] pc,
  input wire logic        cycleEnable,
  input wire logic        tableBusy,
  input wire logic        tableDestError,
  input wire logic [3:0]  statusFlags,
  input wire logic        dmWrite
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // ---------------------------------------------------------
  // properties
  // ---------------------------------------------------------
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  // the decoder port samples only on instruction cycle edges
  dm_on_cycle_a: assert property (
    dmWrite |-> $past(cycleEnable))
    else $error("data write off cycle");
  table_two_cycles_a: assert property (
    $rose(tableBusy) |-> tableBusy[*4] ##1 (!tableBusy && dmWrite))
    else $error("table read not two cycles");
  busy_hold_pc_a: assert property (
    tableBusy && cycleEnable |=> $stable(pc))
    else $error("fetch during table read");
  reset_vector_a: assert property (
    $rose(rstn) |-> (pc == 12'h000)[*3])
    else $error("pc not at reset vector");
  err_sticky_a: assert property (
    tableDestError && !(psel && penable && pwrite
      && paddr == `PMT_OFF_STATUS && pwdata[8]) |=> tableDestError)
    else $error("error flag lost");
  err_cause_a: assert property (
    $rose(tableDestError) |-> $past(cycleEnable && tableReq))
    else $error("error flag without request");
  flags_cause_a: assert property (
    $changed(statusFlags) |-> $past(cycleEnable && aluReq))
    else $error("flags changed without alu op");
  tbl_done_c: cover property ($fell(tableBusy) && dmWrite);
  alu_done_c: cover property (cycleEnable && aluReq ##1 dmWrite);
  dest_err_c: cover property ($rose(tableDestError));
  slv_err_c: cover property (pslverr);
endmodule // pmt_pm_checker
bind pmt_program_memory pmt_pm_checker u_chk (.clk_sys, .rstn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .tableReq, .aluReq, .pc, .cycleEnable, .tableBusy,
  .tableDestError, .statusFlags, .dmWrite);
`default_nettype wire

// ===== pmt_program_memory_tb_top.sv
`include "pmt_defs.vh"
`default_nettype none
module pmt_program_memory_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, pc, jumpAddr;
  logic [31:0] pwdata, prdata, q;
  logic        jumpReq, tableReq, aluReq, cycleEnable, dmWrite, e;
  logic [1:0]  tableKind;
  logic [10:0] tableDest, aluDest, dmAddr, dest;
  logic [3:0]  aluOp, statusFlags;
  logic [7:0]  aluA, aluB, dmData, lo, hi;
  logic        prog_serial_clock, prog_serial_data_in;
  logic        instrValid, serOut, serOe;
  logic [15:0] word, instrWord;
  logic [9:0]  ex;
  int          n_errors, comparisons, cyc, wc, wrCnt;
  logic [3:0]  ops [0:4];
  // ---------------------------------------------------------
  // design and data memory
  // ---------------------------------------------------------
  pmt_program_memory u_pmt_program_memory (.clk_sys, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .jumpReq, .jumpAddr, .tableReq, .tableKind, .tableDest, .aluReq,
    .aluOp, .aluA, .aluB, .aluDest, .pc, .instrWord, .instrValid,
    .cycleEnable, .tableBusy(), .tableDestError(), .statusFlags,
    .dmWrite, .dmAddr, .dmData, .prog_serial_clock,
    .prog_serial_data_in, .prog_serial_data_out(serOut),
    .prog_serial_data_oe(serOe));
  pmt_dm_model u_pmt_dm_model (.clk_sys, .dmWrite, .dmAddr, .dmData,
    .wrCount(wrCnt));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("errors %0d of %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the bench timeout ends a wait that never sees ready
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // request set up one clock before the sampling edge
  task automatic issue(input logic t, input logic [1:0] kind,
                       input logic [3:0] op, input logic [7:0] a, b);
    do @(posedge clk_sys);
    while (cycleEnable !== 1'b1);
    repeat (3) @(posedge clk_sys);
    tableReq <= t;
    aluReq <= !t;
    tableKind <= kind;
    tableDest <= dest;
    aluDest <= dest;
    aluOp <= op;
    aluA <= a;
    aluB <= b;
    @(posedge clk_sys);
    tableReq <= 1'b0;
    aluReq <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  // link programmer: six clocks per half period, bit set while low;
  // a read bit is taken just before the clock falls again
  task automatic ser_frame(input logic rd, input logic [11:0] a,
                           input logic [15:0] d);
    logic [28:0] f;
    logic [15:0] r;
    f = {rd, a, d};
    r = 16'h0000;
    for (int n = 28; n >= 0; n--)
    begin
      prog_serial_data_in <= f[n];
      repeat (6) @(posedge clk_sys);
      prog_serial_clock <= 1'b1;
      repeat (6) @(posedge clk_sys);
      if (n > 0 && n < 17)
        r[n - 1] = serOe ? serOut : 1'bx;
      prog_serial_clock <= 1'b0;
    end
    q = {16'h0000, r};
  endtask
  // returns carry, zero and result
  function automatic logic [9:0] alu_exp(input logic [3:0] op,
                                         input logic [7:0] a, b);
    logic [8:0] s;
    case (op)
      `PMT_ALU_ADD: s = {1'b0, a} + {1'b0, b};
      `PMT_ALU_SUB: s = {1'b1, a} - {1'b0, b};
      `PMT_ALU_AND: s = {1'b0, a & b};
      `PMT_ALU_OR:  s = {1'b0, a | b};
      default:      s = {1'b0, a ^ b};
    endcase
    return {s[8], s[7:0] == 8'h00, s[7:0]};
  endfunction
  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial
  begin
    {clk_sys, rstn, psel, penable, pwrite, jumpReq, tableReq} = '0;
    {aluReq, prog_serial_clock, prog_serial_data_in} = '0;
    {paddr, pwdata, jumpAddr, tableKind, tableDest, aluDest} = '0;
    {aluOp, aluA, aluB, n_errors, comparisons, cyc, dest} = '0;
    ops = '{`PMT_ALU_ADD, `PMT_ALU_SUB, `PMT_ALU_AND, `PMT_ALU_OR,
            `PMT_ALU_XOR};
    void'($urandom(32'h21BA4337));
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    check({20'h0, pc}, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      lo = (i < 4) ? {8{i[0]}} : 8'($urandom);
      hi = 8'($urandom);
      word = 16'($urandom);
      dest = {i[1] ? 3'(1 + $urandom % 6) : 3'h0, 8'($urandom)};
      apb(1'b1, `PMT_OFF_PROG_ADDR, {20'h0, i[0] ? 4'hF : hi[3:0], lo});
      apb(1'b1, `PMT_OFF_PROG_DATA, {16'h0, word});
      apb(1'b1, `PMT_OFF_PTR_LOW, {24'h0, lo});
      apb(1'b1, `PMT_OFF_PTR_HIGH, {24'h0, hi});
      issue(1'b1, i[1:0], 4'h0, 8'h00, 8'h00);
      check({24'h0, u_pmt_dm_model.mem[dest]}, {24'h0, word[7:0]});
      // no second table read may slip in before the high byte is saved
      apb(1'b0, `PMT_OFF_TBL_HIGH, 32'h0);
      check(q, {24'h0, word[15:8]});
    end
    lo = 8'($urandom);
    apb(1'b1, `PMT_OFF_TBL_HIGH, {24'h0, lo});
    apb(1'b0, `PMT_OFF_TBL_HIGH, 32'h0);
    check(q, {24'h0, lo});
    wc = wrCnt;
    dest = 11'h2A5;
    issue(1'b1, `PMT_TBL_STD, 4'h0, 8'h00, 8'h00);
    check(wrCnt, wc);
    apb(1'b0, `PMT_OFF_STATUS, 32'h0);
    check({31'h0, q[12]}, 32'h1);
    apb(1'b1, `PMT_OFF_STATUS, 32'h100);
    apb(1'b0, `PMT_OFF_STATUS, 32'h0);
    check({31'h0, q[12]}, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      lo = 8'($urandom);
      hi = (i == 1) ? lo : 8'($urandom);
      dest = {3'h0, 8'($urandom)};
      ex = alu_exp(ops[i % 5], lo, hi);
      issue(1'b0, 2'h0, ops[i % 5], lo, hi);
      check({24'h0, u_pmt_dm_model.mem[dest]}, {24'h0, ex[7:0]});
      check({31'h0, statusFlags[`PMT_FLAG_Z]}, {31'h0, ex[8]});
      if (i % 5 < 2)
        check({31'h0, statusFlags[`PMT_FLAG_C]}, {31'h0, ex[9]});
    end
    // a held jump keeps refetching the word stored at its target
    word = 16'($urandom);
    apb(1'b1, `PMT_OFF_PROG_ADDR, {20'h0, 4'h5, lo});
    apb(1'b1, `PMT_OFF_PROG_DATA, {16'h0, word});
    jumpAddr <= {4'h5, lo};
    jumpReq <= 1'b1;
    issue(1'b0, 2'h0, `PMT_ALU_AND, 8'h00, 8'h00);
    jumpReq <= 1'b0;
    check({20'h0, pc}, {20'h0, 4'h5, lo});
    check({16'h0, instrWord}, {16'h0, word});
    @(posedge clk_sys);
    check({31'h0, instrValid}, 32'h1);
    // serial link: store a word, read it back over apb and the link
    apb(1'b1, `PMT_OFF_CTRL, 32'h1);
    word = 16'($urandom);
    ser_frame(1'b0, {4'h6, lo}, word);
    apb(1'b1, `PMT_OFF_PROG_ADDR, {20'h0, 4'h6, lo});
    apb(1'b0, `PMT_OFF_PROG_DATA, 32'h0);
    check(q, {16'h0, word});
    ser_frame(1'b1, {4'h6, lo}, 16'h0000);
    check(q, {16'h0, word});
    apb(1'b1, `PMT_OFF_CTRL, 32'h0);
    apb(1'b0, 12'h01C, 32'h0);
    check({31'h0, e}, 32'h1);
    wrap_up();
  end
endmodule // pmt_program_memory_tb_top
`default_nettype wire
